// ===== core/gsw_map.vh
`ifndef GSW_MAP_VH
`define GSW_MAP_VH

// ******************************************************
// register indices (byte address is four times the index)
// ******************************************************
`define GSW_IDX_FIRST_GAIN 12'h103
`define GSW_IDX_SECOND_GAIN 12'h107
`define GSW_IDX_MODE 12'h110
`define GSW_IDX_COND 12'h111
`define GSW_IDX_TRANS_1TO2 12'h112
`define GSW_IDX_TRANS_2TO1 12'h113
`define GSW_IDX_WAIT_1TO2 12'h114
`define GSW_IDX_WAIT_2TO1 12'h115
`define GSW_IDX_STATUS 12'h1F0

// ******************************************************
// reset values and field limits
// ******************************************************
`define GSW_RST_GAIN 16'h0190
`define GSW_RST_PARAM 16'h0000
`define GSW_MODE_MANUAL 16'h0000
`define GSW_MODE_AUTO 16'h0001
`define GSW_COND_MAX 16'h0005
`define GSW_COND_COMPLETE_ON 3'h0
`define GSW_COND_COMPLETE_OFF 3'h1
`define GSW_COND_NEAR_ON 3'h2
`define GSW_COND_NEAR_OFF 3'h3
`define GSW_COND_CMD_IDLE 3'h4
`define GSW_COND_CMD_PULSE 3'h5

// ******************************************************
// status fields
// ******************************************************
`define GSW_ST_SECOND 0
`define GSW_ST_WAITING 1
`define GSW_ST_RAMPING 2
`define GSW_ST_GAIN_LSB 16

// ******************************************************
// timing: one millisecond timebase at the core clock rate
// ******************************************************
`define GSW_CLK_HZ 250000000
`define GSW_TICK_MS 1
`define GSW_CYCLES_PER_MS ((`GSW_CLK_HZ / 1000) * `GSW_TICK_MS)

// ******************************************************
// axi response codes
// ******************************************************
`define GSW_RESP_OKAY 2'h0
`define GSW_RESP_SLVERR 2'h2

`endif

// ===== core/gsw_ms_tick.v
`default_nettype none

// ******************************************************
// millisecond timebase divider
// ******************************************************
module gsw_ms_tick
#(
   parameter CYCLES = 250000
)
(
   input wire core_clk,
   input wire resetn,
   input wire restart,
   output reg tick
);

   reg [31:0] count;

   // restart realigns the timebase so a wait or ramp gets whole milliseconds
   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         count <= 32'h00000000;
         tick <= 1'b0;
      end
      else if (restart)
      begin
         count <= 32'h00000000;
         tick <= 1'b0;
      end
      else if (count == CYCLES - 1)
      begin
         count <= 32'h00000000;
         tick <= 1'b1;
      end
      else
      begin
         count <= count + 32'h00000001;
         tick <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ===== core/gsw_gain_switch.v
`include "gsw_map.vh"
`default_nettype none

// Overview of operation
// - mode 0: select input alone picks set
// - mode 1: second set while condition true
// - codes 0-3: complete on/off, near on/off
// - code 4 command idle, 5 pulses arriving
// - transition starts only after wait time
// - ramp first to second over time 1
// - transition time 2 register, default zero
// - mode register, values 0/1, immediate
// - condition register, codes 0-5, immediate
// - ramp second to first over time 2
// - wait time 1 delays first-to-second
// - wait time 2 delays second-to-first
module gsw_gain_switch
#(
   parameter CYCLES_PER_MS = `GSW_CYCLES_PER_MS
)
(
   input wire core_clk,
   input wire resetn,
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire positioning_complete,
   input wire near_position,
   input wire command_filtered_zero,
   input wire command_pulse_active,
   input wire gain_select,
   output reg [15:0] active_gain,
   output reg second_gain_selected
);

   // ******************************************************
   // state encoding
   // ******************************************************
   localparam [1:0] ST_SETTLED = 2'h0;
   localparam [1:0] ST_WAIT = 2'h1;
   localparam [1:0] ST_RAMP = 2'h2;

   reg [15:0] first_gain;
   reg [15:0] second_gain;
   reg [15:0] gain_switch_mode;
   reg [15:0] auto_switch_condition;
   reg [15:0] transition_time_first_to_second;
   reg [15:0] transition_time_second_to_first;
   reg [15:0] wait_time_first_to_second;
   reg [15:0] wait_time_second_to_first;

   reg [1:0] state;
   reg settled_second;
   reg [15:0] ms_count;
   reg [31:0] ramp_err;
   reg [15:0] ramp_target;
   reg [15:0] ramp_diff;
   reg ramp_up;
   reg timer_restart;
   wire ms_tick;

   // ******************************************************
   // millisecond timebase
   // ******************************************************
   gsw_ms_tick #(.CYCLES(CYCLES_PER_MS)) u_tick
   (
      .core_clk(core_clk),
      .resetn(resetn),
      .restart(timer_restart),
      .tick(ms_tick)
   );

   // ******************************************************
   // switching condition
   // ******************************************************
   reg auto_cond;
   reg want_second;

   // unknown codes never reach here since writes above five are refused
   always @*
   begin
      case (auto_switch_condition[2:0])
         `GSW_COND_COMPLETE_ON: auto_cond = positioning_complete;
         `GSW_COND_COMPLETE_OFF: auto_cond = ~positioning_complete;
         `GSW_COND_NEAR_ON: auto_cond = near_position;
         `GSW_COND_NEAR_OFF: auto_cond = ~near_position;
         `GSW_COND_CMD_IDLE: auto_cond = command_filtered_zero & ~command_pulse_active;
         `GSW_COND_CMD_PULSE: auto_cond = command_pulse_active;
         default: auto_cond = 1'b0;
      endcase
      if (gain_switch_mode[0])
         want_second = auto_cond;
      else
         want_second = gain_select;
   end

   // direction-dependent wait and transition times
   wire [15:0] cur_wait = settled_second ? wait_time_second_to_first :
                                           wait_time_first_to_second;
   wire [15:0] cur_trans = settled_second ? transition_time_second_to_first :
                                            transition_time_first_to_second;
   wire [15:0] dest_gain = settled_second ? first_gain : second_gain;
   wire [15:0] settled_gain = settled_second ? second_gain : first_gain;

   // ******************************************************
   // switching sequencer
   // ******************************************************
   // the ramp uses an error accumulator instead of a divider: each
   // millisecond adds the gain span, each clock spends one transition
   // time for one gain step, so the slope stays linear without a division
   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         state <= ST_SETTLED;
         settled_second <= 1'b0;
         ms_count <= 16'h0000;
         ramp_err <= 32'h00000000;
         ramp_target <= `GSW_RST_GAIN;
         ramp_diff <= 16'h0000;
         ramp_up <= 1'b0;
         timer_restart <= 1'b0;
         active_gain <= `GSW_RST_GAIN;
         second_gain_selected <= 1'b0;
      end
      else
      begin
         timer_restart <= 1'b0;
         case (state)
            ST_SETTLED:
            begin
               // follow gain register edits while no switch is pending
               active_gain <= settled_gain;
               if (want_second != settled_second)
               begin
                  state <= ST_WAIT;
                  ms_count <= 16'h0000;
                  timer_restart <= 1'b1;
               end
            end
            ST_WAIT:
            begin
               if (want_second == settled_second)
                  state <= ST_SETTLED; // condition dropped before the wait ran out
               else if (ms_count >= cur_wait)
               begin
                  ms_count <= 16'h0000;
                  timer_restart <= 1'b1;
                  second_gain_selected <= ~settled_second;
                  if (cur_trans == 16'h0000)
                  begin
                     active_gain <= dest_gain;
                     settled_second <= ~settled_second;
                     state <= ST_SETTLED;
                  end
                  else
                  begin
                     state <= ST_RAMP;
                     ramp_target <= dest_gain;
                     ramp_err <= 32'h00000000;
                     ramp_up <= dest_gain >= active_gain;
                     ramp_diff <= (dest_gain >= active_gain) ? dest_gain - active_gain :
                                                              active_gain - dest_gain;
                  end
               end
               else if (ms_tick)
                  ms_count <= ms_count + 16'h0001;
            end
            ST_RAMP:
            begin
               if (ms_tick)
               begin
                  if (ms_count + 16'h0001 >= cur_trans)
                  begin
                     // last millisecond lands exactly on the target
                     active_gain <= ramp_target;
                     settled_second <= ~settled_second;
                     state <= ST_SETTLED;
                  end
                  else
                  begin
                     ms_count <= ms_count + 16'h0001;
                     ramp_err <= ramp_err + {16'h0000, ramp_diff};
                  end
               end
               else if (ramp_err >= {16'h0000, cur_trans})
               begin
                  ramp_err <= ramp_err - {16'h0000, cur_trans};
                  if (ramp_up)
                     active_gain <= active_gain + 16'h0001;
                  else
                     active_gain <= active_gain - 16'h0001;
               end
            end
            default:
               state <= ST_SETTLED;
         endcase
      end
   end

   // ******************************************************
   // axi4-lite write channel
   // ******************************************************
   wire [11:0] wr_idx = s_axi_awaddr[13:2];
   wire [11:0] rd_idx = s_axi_araddr[13:2];
   wire wr_fire = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;

   // merge byte lanes into the low half-word; upper lanes have no storage
   function [15:0] merge;
      input [15:0] old;
      input [31:0] data;
      input [3:0] strb;
      begin
         merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
      end
   endfunction

   wire [15:0] wr_mode = merge(gain_switch_mode, s_axi_wdata, s_axi_wstrb);
   wire [15:0] wr_cond = merge(auto_switch_condition, s_axi_wdata, s_axi_wstrb);

   // address and data are taken together in one cycle, answered next cycle
   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `GSW_RESP_OKAY;
         first_gain <= `GSW_RST_GAIN;
         second_gain <= `GSW_RST_GAIN;
         gain_switch_mode <= `GSW_MODE_MANUAL;
         auto_switch_condition <= `GSW_RST_PARAM;
         transition_time_first_to_second <= `GSW_RST_PARAM;
         transition_time_second_to_first <= `GSW_RST_PARAM;
         wait_time_first_to_second <= `GSW_RST_PARAM;
         wait_time_second_to_first <= `GSW_RST_PARAM;
      end
      else
      begin
         s_axi_awready <= wr_fire;
         s_axi_wready <= wr_fire;
         if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
         else if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `GSW_RESP_OKAY;
            case (wr_idx)
               `GSW_IDX_FIRST_GAIN:
                  first_gain <= merge(first_gain, s_axi_wdata, s_axi_wstrb);
               `GSW_IDX_SECOND_GAIN:
                  second_gain <= merge(second_gain, s_axi_wdata, s_axi_wstrb);
               `GSW_IDX_MODE:
                  // out-of-range values are refused rather than truncated
                  if (wr_mode <= `GSW_MODE_AUTO)
                     gain_switch_mode <= wr_mode;
                  else
                     s_axi_bresp <= `GSW_RESP_SLVERR;
               `GSW_IDX_COND:
                  if (wr_cond <= `GSW_COND_MAX)
                     auto_switch_condition <= wr_cond;
                  else
                     s_axi_bresp <= `GSW_RESP_SLVERR;
               `GSW_IDX_TRANS_1TO2:
                  transition_time_first_to_second <=
                     merge(transition_time_first_to_second, s_axi_wdata, s_axi_wstrb);
               `GSW_IDX_TRANS_2TO1:
                  transition_time_second_to_first <=
                     merge(transition_time_second_to_first, s_axi_wdata, s_axi_wstrb);
               `GSW_IDX_WAIT_1TO2:
                  wait_time_first_to_second <=
                     merge(wait_time_first_to_second, s_axi_wdata, s_axi_wstrb);
               `GSW_IDX_WAIT_2TO1:
                  wait_time_second_to_first <=
                     merge(wait_time_second_to_first, s_axi_wdata, s_axi_wstrb);
               default:
                  s_axi_bresp <= `GSW_RESP_SLVERR;
            endcase
         end
      end
   end

   // ******************************************************
   // axi4-lite read channel
   // ******************************************************
   reg [31:0] rd_value;
   reg rd_ok;

   // status word shows the live sequencer state and the gain in use
   always @*
   begin
      rd_ok = 1'b1;
      rd_value = 32'h00000000;
      case (rd_idx)
         `GSW_IDX_FIRST_GAIN: rd_value = {16'h0000, first_gain};
         `GSW_IDX_SECOND_GAIN: rd_value = {16'h0000, second_gain};
         `GSW_IDX_MODE: rd_value = {16'h0000, gain_switch_mode};
         `GSW_IDX_COND: rd_value = {16'h0000, auto_switch_condition};
         `GSW_IDX_TRANS_1TO2: rd_value = {16'h0000, transition_time_first_to_second};
         `GSW_IDX_TRANS_2TO1: rd_value = {16'h0000, transition_time_second_to_first};
         `GSW_IDX_WAIT_1TO2: rd_value = {16'h0000, wait_time_first_to_second};
         `GSW_IDX_WAIT_2TO1: rd_value = {16'h0000, wait_time_second_to_first};
         `GSW_IDX_STATUS:
         begin
            rd_value[`GSW_ST_SECOND] = second_gain_selected;
            rd_value[`GSW_ST_WAITING] = (state == ST_WAIT);
            rd_value[`GSW_ST_RAMPING] = (state == ST_RAMP);
            rd_value[31:`GSW_ST_GAIN_LSB] = active_gain;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `GSW_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (s_axi_rvalid & s_axi_rready)
            s_axi_rvalid <= 1'b0;
         else if (s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_ok ? `GSW_RESP_OKAY : `GSW_RESP_SLVERR;
         end
      end
   end

endmodule

`default_nettype wire

// ===== verification/gsw_checker.sv
`include "gsw_map.vh"
`default_nettype none

// ******************************************************
// register bus and reset checks
// ******************************************************
module gsw_checker
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] active_gain,
   input wire logic second_gain_selected
);
   timeunit 1ns;
   timeprecision 1ps;
   // a request counts only when no earlier answer is still pending
   wire wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
   wire rd_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
   wire [11:0] wr_idx = s_axi_awaddr[13:2];
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   AST_WR_ANSWER: assert property (wr_take |=> s_axi_awready && s_axi_bvalid)
      else $error("write not answered next cycle");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   AST_RD_ANSWER: assert property (rd_take |=> s_axi_arready && s_axi_rvalid)
      else $error("read not answered next cycle");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before taken");
   // reset must not be masked here, it is the cause being checked
   AST_RESET_OUT: assert property (disable iff (1'b0) !resetn |=> active_gain == `GSW_RST_GAIN && !second_gain_selected)
      else $error("outputs not at reset values");
   AST_MODE_RANGE: assert property (wr_take && wr_idx == `GSW_IDX_MODE && s_axi_wdata[15:0] > `GSW_MODE_AUTO |=> s_axi_bresp == `GSW_RESP_SLVERR)
      else $error("mode above one accepted");
   AST_COND_RANGE: assert property (wr_take && wr_idx == `GSW_IDX_COND && s_axi_wdata[15:0] > `GSW_COND_MAX |=> s_axi_bresp == `GSW_RESP_SLVERR)
      else $error("condition above five accepted");
   AST_UNMAPPED_RD: assert property (rd_take && s_axi_araddr[13:2] == 12'h120 |=> s_axi_rresp == `GSW_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
endmodule

bind gsw_gain_switch gsw_checker u_chk (.core_clk(core_clk), .resetn(resetn),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .active_gain(active_gain), .second_gain_selected(second_gain_selected));

`default_nettype wire

// ===== verification/gsw_loop_model.sv
`default_nettype none

// ******************************************************
// control loop status source
// ******************************************************
module gsw_loop_model
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [3:0] loop_state,
   output logic positioning_complete,
   output logic near_position,
   output logic command_filtered_zero,
   output logic command_pulse_active
);
   timeunit 1ns;
   timeprecision 1ps;
   // status is registered: the loops report one cycle after they settle
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         {positioning_complete, near_position, command_filtered_zero, command_pulse_active} <= 4'h0;
      end
      else
      begin
         {positioning_complete, near_position, command_filtered_zero, command_pulse_active} <= loop_state;
      end
   end
endmodule

`default_nettype wire

// ===== verification/tb_gsw_gain_switch.sv
`include "gsw_map.vh"
`default_nettype none

module tb_gsw_gain_switch;
   timeunit 1ns;
   timeprecision 1ps;
   // ******************************************************
   // addresses, stimulus tables, signals
   // ******************************************************
   localparam logic [31:0] A_MODE = {18'h0, `GSW_IDX_MODE, 2'h0};
   localparam logic [31:0] A_COND = {18'h0, `GSW_IDX_COND, 2'h0};
   localparam logic [31:0] A_T12 = {18'h0, `GSW_IDX_TRANS_1TO2, 2'h0};
   localparam logic [31:0] A_T21 = {18'h0, `GSW_IDX_TRANS_2TO1, 2'h0};
   localparam logic [31:0] A_W12 = {18'h0, `GSW_IDX_WAIT_1TO2, 2'h0};
   localparam logic [31:0] A_W21 = {18'h0, `GSW_IDX_WAIT_2TO1, 2'h0};
   localparam logic [31:0] A_G1 = {18'h0, `GSW_IDX_FIRST_GAIN, 2'h0};
   localparam logic [31:0] A_G2 = {18'h0, `GSW_IDX_SECOND_GAIN, 2'h0};
   localparam logic [31:0] A_ST = {18'h0, `GSW_IDX_STATUS, 2'h0};
   localparam logic [31:0] A_BAD = 32'h00000480;
   localparam logic [31:0] LO = 32'h0000FFFF;
   localparam logic [1:0] OK = `GSW_RESP_OKAY;
   localparam logic [1:0] ERR = `GSW_RESP_SLVERR;
   // loop status per condition code, bits are complete, near, zero, pulse
   localparam logic [3:0] ST_ON [6] = '{4'h8, 4'h0, 4'h4, 4'h0, 4'h2, 4'h1};
   localparam logic [3:0] ST_OFF [6] = '{4'h0, 4'h8, 4'h0, 4'h4, 4'h3, 4'h2};
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, gain_select = 1'b0;
   logic [3:0] loop_state = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [15:0] active_gain;
   logic second_gain_selected, pos_done, pos_near, cmd_zero, cmd_pulse;
   int err_total = 0;
   int n_compared = 0;
   int cycles = 0;

   always #2 core_clk = ~core_clk;

   // short ms timebase keeps the ramps within a few dozen cycles
   gsw_gain_switch #(.CYCLES_PER_MS(10)) u_dut (.core_clk(core_clk), .resetn(resetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .positioning_complete(pos_done), .near_position(pos_near),
      .command_filtered_zero(cmd_zero), .command_pulse_active(cmd_pulse),
      .gain_select(gain_select), .active_gain(active_gain),
      .second_gain_selected(second_gain_selected));

   gsw_loop_model u_loop (.core_clk(core_clk), .resetn(resetn), .loop_state(loop_state),
      .positioning_complete(pos_done), .near_position(pos_near),
      .command_filtered_zero(cmd_zero), .command_pulse_active(cmd_pulse));

   // ******************************************************
   // shared tasks
   // ******************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      if (err_total == 0 && n_compared > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // response is taken only once bvalid and bready meet at an edge
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1 && !s_axi_bready)
            s_axi_bready <= 1'b1;
      end
      while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1));
      check(32'(s_axi_bresp), 32'(er));
      s_axi_bready <= 1'b0;
   endtask

   // rready comes late on purpose so read data must stand meanwhile
   task automatic axi_rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
      input logic [1:0] er);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1 && !s_axi_rready)
            s_axi_rready <= 1'b1;
      end
      while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
      check(s_axi_rdata & m, e);
      check(32'(s_axi_rresp), 32'(er));
      s_axi_rready <= 1'b0;
   endtask

   task automatic wait_gain(input logic [15:0] g, input int n);
      for (int i = 0; i < n && active_gain !== g; i++)
         @(posedge core_clk);
      check(32'(active_gain), 32'(g));
   endtask

   task automatic mid_ramp();
      check(32'(active_gain > 16'h0100 && active_gain < 16'h0200), 32'h1);
   endtask

   // hang guard, far above the few hundred cycles the run needs
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         err_total++;
         print_verdict();
      end
   end

   // ******************************************************
   // scenarios
   // ******************************************************
   initial
   begin
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      axi_rd(A_MODE, LO, 32'h0, OK);
      axi_rd(A_COND, LO, 32'h0, OK);
      axi_rd(A_T12, LO, 32'h0, OK);
      axi_rd(A_T21, LO, 32'h0, OK);
      axi_rd(A_W12, LO, 32'h0, OK);
      axi_rd(A_W21, LO, 32'h0, OK);
      axi_wr(A_MODE, 32'h2, ERR);
      axi_wr(A_COND, 32'h6, ERR);
      axi_rd(A_MODE, LO, 32'h0, OK);
      axi_rd(A_COND, LO, 32'h0, OK);
      axi_rd(A_BAD, 32'hFFFFFFFF, 32'h0, ERR);
      axi_wr(A_T21, 32'hFFFF, OK);
      axi_rd(A_T21, 32'hFFFFFFFF, 32'h0000FFFF, OK);
      axi_wr(A_T21, 32'h0, OK);
      axi_wr(A_G1, 32'h0100, OK);
      axi_wr(A_G2, 32'h0200, OK);
      wait_gain(16'h0100, 5);
      // manual mode ignores a true automatic condition
      loop_state <= 4'h8;
      repeat (10) @(posedge core_clk);
      check(32'(active_gain), 32'h0100);
      gain_select <= 1'b1;
      wait_gain(16'h0200, 5);
      check(32'(second_gain_selected), 32'h1);
      axi_rd(A_ST, 32'hFFFF0007, 32'h02000001, OK);
      gain_select <= 1'b0;
      wait_gain(16'h0100, 5);
      // wait time 1 of three milliseconds
      axi_wr(A_W12, 32'h3, OK);
      gain_select <= 1'b1;
      repeat (25) @(posedge core_clk);
      check(32'(active_gain), 32'h0100);
      check(32'(second_gain_selected), 32'h0);
      // status must report the pending wait while it runs
      axi_rd(A_ST, 32'h00000007, 32'h00000002, OK);
      wait_gain(16'h0200, 20);
      gain_select <= 1'b0;
      wait_gain(16'h0100, 5);
      // ramp up over four milliseconds
      axi_wr(A_W12, 32'h0, OK);
      axi_wr(A_T12, 32'h4, OK);
      gain_select <= 1'b1;
      repeat (20) @(posedge core_clk);
      mid_ramp();
      axi_rd(A_ST, 32'h00000007, 32'h00000005, OK);
      wait_gain(16'h0200, 40);
      // ramp down after wait time 2
      axi_wr(A_W21, 32'h2, OK);
      axi_wr(A_T21, 32'h4, OK);
      gain_select <= 1'b0;
      repeat (15) @(posedge core_clk);
      check(32'(active_gain), 32'h0200);
      // first ramp step lands about thirteen cycles after the wait ends
      repeat (30) @(posedge core_clk);
      mid_ramp();
      check(32'(second_gain_selected), 32'h0);
      wait_gain(16'h0100, 50);
      axi_wr(A_W21, 32'h0, OK);
      axi_wr(A_T21, 32'h0, OK);
      axi_wr(A_T12, 32'h0, OK);
      // automatic mode: every condition code, select input held high
      axi_wr(A_MODE, 32'h1, OK);
      loop_state <= ST_OFF[0];
      gain_select <= 1'b1;
      for (int c = 0; c < 6; c++)
      begin
         axi_wr(A_COND, 32'(c), OK);
         loop_state <= ST_ON[c];
         wait_gain(16'h0200, 10);
         loop_state <= ST_OFF[c];
         wait_gain(16'h0100, 10);
      end
      print_verdict();
   end
endmodule

`default_nettype wire
